// *** shared/sere_pkg.sv ***
// constants and types shared by both ends of the serial eeprom link
// What this block does
// - master loads word address by address-only write
// - repeated start ends write, keeps pointer
// - read control byte acked, byte shifted out
// - master nack ends read, device releases
// - master ack requests next sequential byte
// - pointer increments after every data byte
// - low supply blocks all array writes
// - data pin open drain, never driven high
// - data changes only while clock low
// - write protect low allows full range
// - write protect high blocks every write
// - chip selects must match control byte
// - middle chip select compared inverted
// - block select bits are address top
// - no acknowledge during programming cycle
// - release data line after final nack
package sere_pkg;
  localparam int ADDR_W = 11;
  localparam int MEM_DEPTH = 2048;
  localparam logic [3:0] CTRL_LEAD = 4'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  // programming cycle length in core clocks (kept short on purpose)
  localparam logic [7:0] PROG_CYCLES = 8'h40;
  // link clock divider: half period of the master's serial clock
  localparam int CORE_NS = 50;
  localparam int HALF_NS = 2500;
  localparam logic [7:0] HALF_CYC = 8'(HALF_NS / CORE_NS);
  localparam logic [7:0] QTR_CYC = 8'(HALF_NS / CORE_NS / 2);
  typedef enum logic [2:0] {
    SERE_IDLE, SERE_CTRL, SERE_WADDR, SERE_WDATA, SERE_RDATA, SERE_RACK
  } sere_dev_st_t;
  typedef enum logic [3:0] {
    SERE_M_IDLE, SERE_M_START, SERE_M_BIT, SERE_M_ACK, SERE_M_RSTART,
    SERE_M_STOP, SERE_M_DONE
  } sere_host_st_t;
endpackage

// *** shared/sere_if.sv ***
// two-wire link joining master and eeprom ends
`timescale 1ns/1ps
interface sere_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda_i;
  // wired-and with pull-up
  assign sda_i = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
  modport dev (input scl, input sda_i, output sda_d_o, output sda_d_oe);
  modport host (output scl, input sda_i, output sda_m_o, output sda_m_oe);
endinterface

// *** design/sere_eeprom.sv ***
// two-wire eeprom end: address pointer, array, protect and select logic
`timescale 1ns/1ps
module sere_eeprom (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // link
  sere_if.dev LINK,
  // straps and supply status
  input wire logic [2:0] CHIP_SEL,
  input wire logic WRITE_PROTECT,
  input wire logic SUPPLY_LOW,
  // status
  output logic BUSY,
  output logic [10:0] POINTER
);
  logic [7:0] mem [0:sere_pkg::MEM_DEPTH-1];
  logic [1:0] scl_s_q, sda_s_q, wp_s_q, low_s_q;
  logic [2:0] cs_s0_q, cs_s1_q;
  logic scl_q, sda_q;
  logic oe_q;
  sere_pkg::sere_dev_st_t st_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic ack_ph_q;
  logic [10:0] ptr_q;
  logic [7:0] wbyte_q;
  logic wpend_q, wvalid_q;
  logic [7:0] prog_q;
  logic start_ev, stop_ev, rise, fall, sel_ok, byte_done;
  logic [7:0] rx;

  function automatic logic [10:0] inc(input logic [10:0] a);
    inc = a + sere_pkg::ADDR_ONE;
  endfunction

  // link pins and straps pass two flops before use
  always_ff @(posedge CORE_CLK) begin
    scl_s_q <= {scl_s_q[0], LINK.scl};
    sda_s_q <= {sda_s_q[0], LINK.sda_i};
    wp_s_q <= {wp_s_q[0], WRITE_PROTECT};
    low_s_q <= {low_s_q[0], SUPPLY_LOW};
    cs_s0_q <= CHIP_SEL;
    cs_s1_q <= cs_s0_q;
    scl_q <= scl_s_q[1];
    sda_q <= sda_s_q[1];
  end

  assign rise = scl_s_q[1] && !scl_q;
  assign fall = !scl_s_q[1] && scl_q;
  assign start_ev = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
  assign stop_ev = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
  assign rx = {sh_q[6:0], sda_s_q[1]};
  assign byte_done = rise && !ack_ph_q && bit_q == sere_pkg::BIT_LAST;
  // middle select inverted, others direct
  assign sel_ok = rx[7:4] == {sere_pkg::CTRL_LEAD[0], cs_s1_q[2],
                  !cs_s1_q[1], cs_s1_q[0]};

  // protocol state
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_q <= sere_pkg::SERE_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ack_ph_q <= 1'b0;
      oe_q <= 1'b0;
      ptr_q <= sere_pkg::ADDR_ZERO;
      wbyte_q <= 8'h00;
      wvalid_q <= 1'b0;
      wpend_q <= 1'b0;
    end else begin
      wpend_q <= 1'b0;
      if (start_ev) begin
        // repeated start drops a pending write, keeps the pointer
        st_q <= sere_pkg::SERE_CTRL;
        bit_q <= 3'h0;
        ack_ph_q <= 1'b0;
        oe_q <= 1'b0;
        wvalid_q <= 1'b0;
      end else if (stop_ev) begin
        st_q <= sere_pkg::SERE_IDLE;
        oe_q <= 1'b0;
        wpend_q <= wvalid_q;
        wvalid_q <= 1'b0;
      end else if (st_q != sere_pkg::SERE_IDLE) begin
        if (rise && !ack_ph_q) begin
          sh_q <= rx;
          bit_q <= bit_q + 3'h1;
        end
        if (byte_done) begin
          case (st_q)
            sere_pkg::SERE_CTRL: begin
              if (sel_ok && prog_q == 8'h00) begin
                ptr_q <= {rx[3:1], ptr_q[7:0]};
                st_q <= rx[0] ? sere_pkg::SERE_RDATA
                              : sere_pkg::SERE_WADDR;
              end else begin
                st_q <= sere_pkg::SERE_IDLE;
              end
            end
            sere_pkg::SERE_WADDR: begin
              ptr_q <= {ptr_q[10:8], rx};
              st_q <= sere_pkg::SERE_WDATA;
            end
            sere_pkg::SERE_WDATA: begin
              wbyte_q <= rx;
              wvalid_q <= 1'b1;
            end
            default: st_q <= st_q;
          endcase
          if (st_q != sere_pkg::SERE_RDATA) begin
            ack_ph_q <= 1'b1;
          end
        end
        // drive only on falling edges, while the clock is low
        if (fall) begin
          if (ack_ph_q && st_q == sere_pkg::SERE_RACK) begin
            ack_ph_q <= 1'b0;
            oe_q <= 1'b0;
          end else if (ack_ph_q && st_q != sere_pkg::SERE_IDLE) begin
            oe_q <= !oe_q; // ack low, then release, or drive the first bit in a read
            if (oe_q) begin
              ack_ph_q <= 1'b0;
              bit_q <= 3'h0;
              if (st_q == sere_pkg::SERE_RDATA) begin
                oe_q <= !mem[ptr_q][7];
              end
            end
          end else if (st_q == sere_pkg::SERE_RDATA) begin
            oe_q <= !mem[ptr_q][3'h7 - bit_q];
          end
        end
        // read byte over: release and look at the master's answer
        if (st_q == sere_pkg::SERE_RDATA && byte_done) begin
          st_q <= sere_pkg::SERE_RACK;
          ptr_q <= inc(ptr_q);
        end
        if (st_q == sere_pkg::SERE_RACK && fall && !ack_ph_q) begin
          oe_q <= 1'b0;
        end
        if (st_q == sere_pkg::SERE_RACK && rise) begin
          bit_q <= 3'h0;
          if (sda_s_q[1]) begin
            st_q <= sere_pkg::SERE_IDLE;
          end else begin
            // next byte starts on the coming fall, no ack slot of ours
            st_q <= sere_pkg::SERE_RDATA;
          end
        end
        if (st_q == sere_pkg::SERE_WDATA && byte_done) begin
          ptr_q <= {ptr_q[10:4], ptr_q[3:0] + 4'h1};
        end
      end
    end
  end

  // programming cycle: write only when protect low and supply good
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      prog_q <= 8'h00;
    end else if (wpend_q && !wp_s_q[1] && !low_s_q[1]) begin
      prog_q <= sere_pkg::PROG_CYCLES;
      mem[{ptr_q[10:4], ptr_q[3:0] - 4'h1}] <= wbyte_q;
    end else if (prog_q != 8'h00) begin
      prog_q <= prog_q - 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      BUSY <= 1'b0;
      POINTER <= sere_pkg::ADDR_ZERO;
    end else begin
      BUSY <= prog_q != 8'h00;
      POINTER <= ptr_q;
    end
  end

  assign LINK.sda_d_o = 1'b0;
  assign LINK.sda_d_oe = oe_q;
endmodule

// *** design/sere_master.sv ***
// two-wire master end: random and sequential reads, single-byte writes
`timescale 1ns/1ps
module sere_master (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // link
  sere_if.host LINK,
  // request
  input wire logic REQ,
  input wire logic REQ_WRITE,
  input wire logic [2:0] REQ_SEL,
  input wire logic [10:0] REQ_ADDR,
  input wire logic [7:0] REQ_WDATA,
  input wire logic [7:0] REQ_LEN,
  // answer
  output logic BUSY,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic DONE,
  output logic NACK
);
  typedef enum logic [1:0] {
    SERE_B_CTRL, SERE_B_ADDR, SERE_B_DATA, SERE_B_READ
  } sere_byte_t;
  // slot timing: fall at zero, drive at a quarter, rise at half
  localparam logic [7:0] T_RELEASE = 8'h01;
  localparam logic [7:0] T_DRIVE = sere_pkg::QTR_CYC;
  localparam logic [7:0] T_RISE = sere_pkg::HALF_CYC;
  localparam logic [7:0] T_SAMPLE = sere_pkg::HALF_CYC + sere_pkg::QTR_CYC;
  localparam logic [7:0] T_END = sere_pkg::HALF_CYC + sere_pkg::HALF_CYC
                                 - 8'h01;

  sere_pkg::sere_host_st_t st_q;
  sere_byte_t kind_q;
  logic [7:0] cnt_q;
  logic [1:0] sda_s_q;
  logic scl_q, oe_q, o_q;
  logic [2:0] bit_q;
  logic [7:0] tx_q, rx_q, left_q;
  logic w_q, rs_q, nack_q;
  logic [2:0] sel_q;
  logic [10:0] addr_q;
  logic [7:0] wdata_q;
  logic slot_end, rd_end;

  function automatic logic [7:0] ctrl_byte(input logic [2:0] sel,
      input logic [2:0] blk, input logic rd);
    ctrl_byte = {sere_pkg::CTRL_LEAD[0], sel, blk, rd};
  endfunction

  // the returned data line is a pin: two flops before use
  always_ff @(posedge CORE_CLK) begin
    sda_s_q <= {sda_s_q[0], LINK.sda_i};
  end

  assign slot_end = cnt_q == T_END;
  assign rd_end = st_q == sere_pkg::SERE_M_ACK && kind_q == SERE_B_READ &&
                  slot_end;

  // slot timer
  always_ff @(posedge CORE_CLK) begin
    if (RESET || st_q == sere_pkg::SERE_M_IDLE || slot_end) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // serial clock: stands high between transfers
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      scl_q <= 1'b1;
    end else if (st_q == sere_pkg::SERE_M_IDLE ||
                 st_q == sere_pkg::SERE_M_DONE) begin
      scl_q <= 1'b1;
    end else if (cnt_q == 8'h00) begin
      scl_q <= 1'b0;
    end else if (cnt_q == T_RISE) begin
      scl_q <= 1'b1;
    end
  end

  // data line: bits move a quarter into the low phase, after the far end
  // has let go of any acknowledge it was holding
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      oe_q <= 1'b0;
      o_q <= 1'b1;
    end else begin
      case (st_q)
        sere_pkg::SERE_M_START, sere_pkg::SERE_M_RSTART: begin
          if (cnt_q == T_DRIVE) begin
            oe_q <= 1'b0;
          end
          if (cnt_q == T_SAMPLE) begin
            oe_q <= 1'b1;
            o_q <= 1'b0;
          end
        end
        sere_pkg::SERE_M_BIT: begin
          if (kind_q == SERE_B_READ) begin
            if (cnt_q == T_RELEASE) begin
              oe_q <= 1'b0;
            end
          end else if (cnt_q == T_DRIVE) begin
            oe_q <= 1'b1;
            o_q <= tx_q[7];
          end
        end
        sere_pkg::SERE_M_ACK: begin
          if (kind_q != SERE_B_READ) begin
            if (cnt_q == T_RELEASE) begin
              oe_q <= 1'b0;
            end
          end else if (cnt_q == T_DRIVE && left_q != 8'h01) begin
            oe_q <= 1'b1;
            o_q <= 1'b0;
          end
        end
        sere_pkg::SERE_M_STOP: begin
          if (cnt_q == T_DRIVE) begin
            oe_q <= 1'b1;
            o_q <= 1'b0;
          end
          if (cnt_q == T_SAMPLE) begin
            oe_q <= 1'b0;
          end
        end
        default: begin
          oe_q <= 1'b0;
          o_q <= 1'b1;
        end
      endcase
    end
  end

  // transfer sequence
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_q <= sere_pkg::SERE_M_IDLE;
      kind_q <= SERE_B_CTRL;
      bit_q <= 3'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      left_q <= 8'h00;
      w_q <= 1'b0;
      rs_q <= 1'b0;
      nack_q <= 1'b0;
      sel_q <= 3'h0;
      addr_q <= 11'h000;
      wdata_q <= 8'h00;
    end else begin
      case (st_q)
        sere_pkg::SERE_M_IDLE: begin
          // requests are only taken here, so one in flight is refused
          if (REQ) begin
            st_q <= sere_pkg::SERE_M_START;
            w_q <= REQ_WRITE;
            sel_q <= REQ_SEL;
            addr_q <= REQ_ADDR;
            wdata_q <= REQ_WDATA;
            left_q <= REQ_LEN;
            rs_q <= 1'b0;
            nack_q <= 1'b0;
          end
        end
        sere_pkg::SERE_M_START, sere_pkg::SERE_M_RSTART: begin
          if (slot_end) begin
            st_q <= sere_pkg::SERE_M_BIT;
            kind_q <= SERE_B_CTRL;
            bit_q <= 3'h0;
            tx_q <= ctrl_byte(sel_q, addr_q[10:8],
                              st_q == sere_pkg::SERE_M_RSTART);
            rs_q <= st_q == sere_pkg::SERE_M_RSTART;
          end
        end
        sere_pkg::SERE_M_BIT: begin
          if (cnt_q == T_SAMPLE) begin
            rx_q <= {rx_q[6:0], sda_s_q[1]};
          end
          if (slot_end) begin
            tx_q <= {tx_q[6:0], 1'b0};
            bit_q <= bit_q + 3'h1;
            if (bit_q == sere_pkg::BIT_LAST) begin
              st_q <= sere_pkg::SERE_M_ACK;
            end
          end
        end
        sere_pkg::SERE_M_ACK: begin
          if (cnt_q == T_SAMPLE && kind_q != SERE_B_READ && sda_s_q[1]) begin
            nack_q <= 1'b1;
          end
          if (slot_end) begin
            bit_q <= 3'h0;
            if (kind_q == SERE_B_READ) begin
              left_q <= left_q - 8'h01;
              st_q <= left_q == 8'h01 ? sere_pkg::SERE_M_STOP
                                      : sere_pkg::SERE_M_BIT;
            end else if (nack_q) begin
              st_q <= sere_pkg::SERE_M_STOP;
            end else if (kind_q == SERE_B_CTRL && rs_q) begin
              kind_q <= SERE_B_READ;
              st_q <= sere_pkg::SERE_M_BIT;
            end else if (kind_q == SERE_B_CTRL) begin
              kind_q <= SERE_B_ADDR;
              tx_q <= addr_q[7:0];
              st_q <= sere_pkg::SERE_M_BIT;
            end else if (kind_q == SERE_B_ADDR && w_q) begin
              kind_q <= SERE_B_DATA;
              tx_q <= wdata_q;
              st_q <= sere_pkg::SERE_M_BIT;
            end else if (kind_q == SERE_B_ADDR) begin
              st_q <= sere_pkg::SERE_M_RSTART;
            end else begin
              st_q <= sere_pkg::SERE_M_STOP;
            end
          end
        end
        sere_pkg::SERE_M_STOP: begin
          if (slot_end) begin
            st_q <= sere_pkg::SERE_M_DONE;
          end
        end
        default: st_q <= sere_pkg::SERE_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      BUSY <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
      DONE <= 1'b0;
      NACK <= 1'b0;
    end else begin
      BUSY <= st_q != sere_pkg::SERE_M_IDLE;
      RD_VALID <= rd_end;
      if (rd_end) begin
        RD_DATA <= rx_q;
      end
      DONE <= st_q == sere_pkg::SERE_M_DONE;
      NACK <= nack_q;
    end
  end

  assign LINK.scl = scl_q;
  assign LINK.sda_m_o = o_q;
  assign LINK.sda_m_oe = oe_q;
endmodule

// *** dv/sere_link_sva.sv ***
// wire-level checks on the two-wire link between both ends
`timescale 1ns/1ps
module sere_link_sva (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // link
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic sda_i
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_od; sda_d_oe |-> !sda_d_o; endproperty
  a_od: assert property (p_od)
    else $error("eeprom end drives data high");
  property p_dstable; scl && $past(scl) |-> $stable(sda_d_oe); endproperty
  a_dstable: assert property (p_dstable)
    else $error("eeprom end changed data while clock high");
  property p_hichg;
    scl && $past(scl) && $changed(sda_i) |-> !sda_d_oe && !$past(sda_d_oe);
  endproperty
  a_hichg: assert property (p_hichg)
    else $error("data moved under clock high while eeprom drives");
  property p_nocon; sda_d_oe |-> !(sda_m_oe && sda_m_o); endproperty
  a_nocon: assert property (p_nocon)
    else $error("master drives high against eeprom");
  property p_lowmin; $fell(scl) |-> !scl [*8]; endproperty
  a_lowmin: assert property (p_lowmin)
    else $error("clock low phase too short");
  property p_lowmax; $fell(scl) |-> ##[1:200] scl; endproperty
  a_lowmax: assert property (p_lowmax)
    else $error("clock held low too long");
  property p_idle; $fell(RESET) |-> scl && sda_i; endproperty
  a_idle: assert property (p_idle)
    else $error("bus not idle after reset");
  property p_start; scl && $past(scl) && $fell(sda_i) |-> !sda_d_oe;
  endproperty
  a_start: assert property (p_start)
    else $error("eeprom still driving at start");
endmodule

// *** dv/serial_eeprom_read_select_tb_top.sv ***
// self-checking bench: master and eeprom ends against a byte model
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end
module serial_eeprom_read_select_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic wp = 1'b0;
  logic low = 1'b0;
  logic [2:0] req_sel = 3'h0;
  logic [2:0] chip_sel = 3'h0;
  logic [10:0] req_addr = 11'h000;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] req_len = 8'h01;
  logic m_busy, rd_valid, done, nack, d_busy;
  logic [7:0] rd_data;
  logic [10:0] pointer;
  logic [2:0] ok;
  logic [7:0] mem [int];
  logic [7:0] q [$];
  int n_fail = 0;
  int total_checks = 0;
  sere_if link ();
  always #25 core_clk = ~core_clk;
  // middle select bit travels inverted on the wire
  assign ok = chip_sel ^ 3'h2;
  sere_master u_sere_master (.CORE_CLK(core_clk), .RESET(reset),
    .LINK(link), .REQ(req), .REQ_WRITE(req_write), .REQ_SEL(req_sel),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_LEN(req_len),
    .BUSY(m_busy), .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done),
    .NACK(nack));
  sere_eeprom u_sere_eeprom (.CORE_CLK(core_clk), .RESET(reset),
    .LINK(link), .CHIP_SEL(chip_sel), .WRITE_PROTECT(wp),
    .SUPPLY_LOW(low), .BUSY(d_busy), .POINTER(pointer));
  sere_link_sva u_sere_link_sva (.CORE_CLK(core_clk), .RESET(reset),
    .scl(link.scl), .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .sda_i(link.sda_i));
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [2:0] s,
      input logic [10:0] a, input logic [7:0] d, input logic [7:0] n,
      input logic en);
    int k;
    logic seen;
    seen = 1'b0;
    q.delete();
    for (k = 0; k < n && !w && en; k++) q.push_back(mem[(a + k) % 2048]);
    @(posedge core_clk);
    req <= 1'b1;
    req_write <= w;
    req_sel <= s;
    req_addr <= a;
    req_wdata <= d;
    req_len <= n;
    @(posedge core_clk);
    req <= 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
      seen |= d_busy && !w;
      if (rd_valid === 1'b1) `CHK(rd_data, q.pop_front())
    end
    `CHK(done, 1'b1)
    if (!w || !(wp || low)) `CHK(nack, !en)
    `CHK(q.size(), 0)
    `CHK({link.scl, link.sda_i}, 2'h3)
    if (!w) `CHK(seen, 1'b0)
    // the model array only changes when neither inhibit is set
    if (en && w && !wp && !low) mem[a] = d;
    if (en && !w) `CHK(pointer, 11'((a + n) % 2048))
    // covers the whole programming cycle before the next request
    repeat (2 * sere_pkg::PROG_CYCLES) @(posedge core_clk);
  endtask
  initial begin
    int i;
    logic [10:0] ra;
    void'($urandom(32'hF5DD));
    repeat (12) @(posedge core_clk);
    chip_sel <= 3'($urandom());
    reset <= 1'b0;
    ra = 11'($urandom_range(2, 2046));
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, ok, i == 3 ? ra : 11'(i - 1), 8'($urandom()), 8'h01, 1'b1);
    end
    xfer(1'b0, ok, 11'h7FF, 8'h00, 8'h03, 1'b1);
    xfer(1'b0, ok, ra, 8'h00, 8'h01, 1'b1);
    wp <= 1'b1;
    xfer(1'b1, ok, 11'h7FF, 8'($urandom()), 8'h01, 1'b1);
    wp <= 1'b0;
    low <= 1'b1;
    xfer(1'b1, ok, 11'h000, 8'($urandom()), 8'h01, 1'b1);
    low <= 1'b0;
    xfer(1'b0, ok, 11'h7FF, 8'h00, 8'h02, 1'b1);
    xfer(1'b1, chip_sel, ra, 8'h5A, 8'h01, 1'b0);
    xfer(1'b0, ok ^ 3'h1, ra, 8'h00, 8'h01, 1'b0);
    xfer(1'b0, ok ^ 3'h4, ra, 8'h00, 8'h01, 1'b0);
    final_report();
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
endmodule
